// ---- core/sicr_config_bank.sv ----
// Indexed configuration register bank of the super I/O device.
// What this block does
// - Two back-to-back unlock writes to the index port enter configuration mode.
// - Any other-port access between the unlock writes abandons the entry.
// - Exit value written to the index port leaves configuration mode.
// - Index port accepts accesses only while in configuration mode.
// - Data port accesses go to the register that the index selects.
// - Power-up loads defaults; the ordinary reset leaves registers unchanged.
// - Function-enable register at index zero; default depends on part variant.
// - Bit 0 enables disk interface, bit 1 selects AT decoding; both default set.
// - Function bit 3 set keeps floppy powered, clear is low power.
// - Function bit 4 enables the floppy controller.
// - Bits 6:5 set oscillator and baud clock; middle codes follow power good.
// - Bit 7 is a software flag, cleared at power-up.
// - Port-setup register at index one, default 9F.
// - Port-setup bits 1:0 select parallel base or disable it.
// - Port-setup bit 2 keeps the parallel port powered.
// - Port-setup bit 3 set is printer mode, clear allows extended modes.
// - Port-setup bit 4 selects interrupt polarity and float behaviour.
// - In ECP or EPP mode parallel interrupt is active low, floating idle.
// - Clearing lock bit 7 blocks register access until power-up or hard reset.
// - Serial-setup at index two defaults DC; index three defaults 78.
// - Serial bits 1:0 pick primary base; codes 10 and 11 use alternates.
// - Serial bit 2 enables primary port, bit 3 clear powers it down.
// - Serial bits 5:4 pick secondary base; bit 6 enables, bit 7 powers.
`include "sicr_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module sicr_config_bank #(
    parameter bit SECONDARY_VARIANT = 1'b0
) (
    // Clock and resets.
    input wire logic clk,
    input wire logic srst,
    input wire logic por,
    input wire logic hard_rst,
    // Host I/O bus.
    input wire sicr_pkg::sicr_bus_t bus,
    output logic [7:0] rdata,
    output logic rvalid,
    output logic claim,
    // Power good and extended parallel mode.
    input wire logic power_good_input,
    input wire logic lpt_ext_mode,
    // Interrupt sources and pins.
    input wire logic [2:0] irq_src,
    output logic [2:0] irq_out,
    output logic [2:0] irq_oe,
    // Decoded controls.
    output sicr_pkg::sicr_ctl_t ctl
);
    import sicr_pkg::*;

    sicr_state_t st_r;
    sicr_state_t st_nxt;

    function automatic logic [9:0] com_base(input logic sel);
        com_base = sel ? `SICR_COM_2F8 : `SICR_COM_3F8;
    endfunction : com_base

    logic idx_hit;
    logic dat_hit;
    logic other_acc;
    logic unlocked;
    assign idx_hit = bus.addr == `SICR_INDEX_PORT;
    assign dat_hit = bus.addr == `SICR_DATA_PORT;
    assign other_acc = (bus.wr || bus.rd) && !idx_hit;
    assign unlocked = st_r.port[`SICR_PORT_LOCK];

    always_comb begin
        st_nxt = st_r;
        st_nxt.rvalid = 1'b0;
        unique case (st_r.mode)
            SICR_CLOSED: begin
                if (bus.wr && idx_hit && bus.wdata == `SICR_UNLOCK_VAL) begin
                    st_nxt.mode = SICR_ARMED;
                end
            end
            SICR_ARMED: begin
                if (other_acc || (bus.wr && bus.wdata != `SICR_UNLOCK_VAL)) begin
                    st_nxt.mode = SICR_CLOSED;
                end else if (bus.wr) begin
                    st_nxt.mode = SICR_OPEN;
                end
            end
            SICR_OPEN: begin
                if (bus.wr && idx_hit) begin
                    if (bus.wdata == `SICR_EXIT_VAL) begin
                        st_nxt.mode = SICR_CLOSED;
                    end else begin
                        st_nxt.index = bus.wdata[3:0];
                    end
                end else if (bus.rd && idx_hit) begin
                    st_nxt.rdata = {4'h0, st_r.index};
                    st_nxt.rvalid = 1'b1;
                end else if (dat_hit && unlocked) begin
                    if (bus.wr) begin
                        unique case (st_r.index)
                            `SICR_IDX_FUNC: st_nxt.func = bus.wdata;
                            `SICR_IDX_PORT: st_nxt.port = bus.wdata;
                            `SICR_IDX_SERIAL: st_nxt.serial = bus.wdata;
                            `SICR_IDX_FLOPPY: st_nxt.floppy = bus.wdata;
                            default: ;
                        endcase
                    end else if (bus.rd) begin
                        st_nxt.rvalid = 1'b1;
                        unique case (st_r.index)
                            `SICR_IDX_FUNC: st_nxt.rdata = st_r.func;
                            `SICR_IDX_PORT: st_nxt.rdata = st_r.port;
                            `SICR_IDX_SERIAL: st_nxt.rdata = st_r.serial;
                            `SICR_IDX_FLOPPY: st_nxt.rdata = st_r.floppy;
                            default: st_nxt.rdata = 8'h00;
                        endcase
                    end
                end
            end
            default: st_nxt.mode = SICR_CLOSED;
        endcase
        // Hard reset re-opens the lock only; other contents keep their values.
        if (hard_rst) begin
            st_nxt.port[`SICR_PORT_LOCK] = 1'b1;
        end
        // Ordinary reset leaves the registers alone; it closes the mode and clears the read-valid flag.
        if (srst) begin
            st_nxt.mode = SICR_CLOSED;
            st_nxt.rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (por) begin
            st_r <= '0;
            st_r.func <= SECONDARY_VARIANT ? `SICR_FUNC_RST_SEC : `SICR_FUNC_RST_PRI;
            st_r.port <= `SICR_PORT_RST;
            st_r.serial <= `SICR_SERIAL_RST;
            st_r.floppy <= `SICR_FLOPPY_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata = st_r.rdata;
    assign rvalid = st_r.rvalid;
    assign claim = (st_r.mode == SICR_OPEN) && (idx_hit || (dat_hit && unlocked))
        && (bus.rd || bus.wr);

    logic osc_gated;
    assign osc_gated = st_r.func[6] ^ st_r.func[5];

    always_comb begin
        ctl.disk_en = st_r.func[`SICR_FUNC_DISK_EN];
        ctl.disk_at = st_r.func[`SICR_FUNC_DISK_AT];
        ctl.fdc_pwr = st_r.func[`SICR_FUNC_FDC_PWR];
        ctl.fdc_en = st_r.func[`SICR_FUNC_FDC_EN];
        ctl.osc_run = (st_r.func[6:5] == 2'b00) || (osc_gated && power_good_input);
        ctl.brg_run = ctl.osc_run;
        ctl.cfg_valid = st_r.func[`SICR_FUNC_VALID];
        ctl.lpt_en = st_r.port[1:0] != 2'b00;
        unique case (st_r.port[1:0])
            2'b01: ctl.lpt_base = `SICR_LPT_3BC;
            2'b10: ctl.lpt_base = `SICR_LPT_378;
            2'b11: ctl.lpt_base = `SICR_LPT_278;
            default: ctl.lpt_base = 10'h000;
        endcase
        ctl.lpt_pwr = st_r.port[`SICR_PORT_LPT_PWR];
        ctl.lpt_std = st_r.port[`SICR_PORT_LPT_STD];
        ctl.irq_pol_high = st_r.port[`SICR_PORT_IRQ_POL];
        ctl.alt_serial_sel = st_r.port[6:5];
        ctl.u1_sel = st_r.serial[1:0];
        ctl.u1_alt = st_r.serial[1];
        ctl.u1_base = com_base(st_r.serial[0]);
        ctl.u1_en = st_r.serial[`SICR_SER_U1_EN];
        ctl.u1_pwr = st_r.serial[`SICR_SER_U1_PWR];
        ctl.u2_sel = st_r.serial[5:4];
        ctl.u2_alt = st_r.serial[5];
        ctl.u2_base = com_base(st_r.serial[4]);
        ctl.u2_en = st_r.serial[`SICR_SER_U2_EN];
        ctl.u2_pwr = st_r.serial[`SICR_SER_U2_PWR];
    end

    // Interrupt pins: index 0 serial, 1 floppy, 2 parallel.
    logic [2:0] act_high;
    always_comb begin
        act_high = {3{st_r.port[`SICR_PORT_IRQ_POL]}};
        if (lpt_ext_mode && !st_r.port[`SICR_PORT_LPT_STD]) begin
            act_high[2] = 1'b0;
        end
        for (int i = 0; i < 3; i++) begin
            irq_out[i] = act_high[i] ? irq_src[i] : 1'b0;
            irq_oe[i] = act_high[i] ? 1'b1 : irq_src[i];
        end
    end

    enter_mode_a: assert property (@(posedge clk) disable iff (srst || por)
        st_r.mode == SICR_ARMED && bus.wr && idx_hit && bus.wdata == `SICR_UNLOCK_VAL
        |=> st_r.mode == SICR_OPEN) else $error("unlock pair did not open mode");
    abandon_entry_a: assert property (@(posedge clk) disable iff (srst || por)
        st_r.mode == SICR_ARMED && other_acc |=> st_r.mode == SICR_CLOSED)
        else $error("entry not abandoned");
    exit_mode_a: assert property (@(posedge clk) disable iff (srst || por)
        st_r.mode == SICR_OPEN && bus.wr && idx_hit && bus.wdata == `SICR_EXIT_VAL
        |=> st_r.mode == SICR_CLOSED) else $error("exit value ignored");
    index_load_a: assert property (@(posedge clk) disable iff (srst || por || hard_rst)
        st_r.mode != SICR_OPEN |=> $stable(st_r.index)) else $error("index changed");
    route_write_a: assert property (@(posedge clk) disable iff (srst || por || hard_rst)
        st_r.mode == SICR_OPEN && unlocked && dat_hit && bus.wr && !bus.rd
        && st_r.index == `SICR_IDX_SERIAL |=> st_r.serial == $past(bus.wdata))
        else $error("data write misrouted");
    lock_block_a: assert property (@(posedge clk) disable iff (srst || por || hard_rst)
        !unlocked |=> !unlocked && $stable(st_r.func) && $stable(st_r.serial))
        else $error("locked registers changed");
    closed_keep_a: assert property (@(posedge clk) disable iff (por || hard_rst)
        st_r.mode != SICR_OPEN |=> $stable(st_r.func) && $stable(st_r.port))
        else $error("registers changed outside mode");
    read_back_a: assert property (@(posedge clk) disable iff (srst || por)
        st_r.mode == SICR_OPEN && unlocked && dat_hit && bus.rd && !bus.wr
        && st_r.index == `SICR_IDX_PORT |=> rvalid && rdata == $past(st_r.port))
        else $error("read data wrong");
    osc_stop_a: assert property (@(posedge clk)
        st_r.func[6:5] == 2'b11 |-> !ctl.osc_run && !ctl.brg_run)
        else $error("oscillator not stopped");
    ext_irq_a: assert property (@(posedge clk)
        lpt_ext_mode && !st_r.port[`SICR_PORT_LPT_STD] && !irq_src[2]
        |-> !irq_oe[2]) else $error("parallel interrupt not floated");
    ext_drive_a: assert property (@(posedge clk)
        lpt_ext_mode && !st_r.port[`SICR_PORT_LPT_STD] && irq_src[2]
        |-> irq_oe[2] && !irq_out[2]) else $error("parallel interrupt not driven low");
    pol_high_a: assert property (@(posedge clk)
        st_r.port[`SICR_PORT_IRQ_POL] && !(lpt_ext_mode && !st_r.port[`SICR_PORT_LPT_STD])
        |-> irq_oe[2] && irq_out[2] == irq_src[2]) else $error("interrupt polarity wrong");
    claim_open_a: assert property (@(posedge clk)
        claim |-> st_r.mode == SICR_OPEN) else $error("claim outside mode");
    closed_quiet_a: assert property (@(posedge clk) disable iff (srst || por)
        st_r.mode != SICR_OPEN |=> !rvalid) else $error("read answered outside mode");
    hard_unlock_a: assert property (@(posedge clk) disable iff (por)
        hard_rst |=> unlocked) else $error("hard reset did not unlock");
    srst_close_a: assert property (@(posedge clk) disable iff (por)
        srst |=> st_r.mode == SICR_CLOSED) else $error("ordinary reset left mode open");
    index_write_a: assert property (@(posedge clk) disable iff (srst || por)
        st_r.mode == SICR_OPEN && bus.wr && idx_hit && bus.wdata != `SICR_EXIT_VAL
        |=> st_r.index == $past(bus.wdata[3:0])) else $error("index not loaded");
    index_read_a: assert property (@(posedge clk) disable iff (srst || por)
        st_r.mode == SICR_OPEN && bus.rd && !bus.wr && idx_hit
        |=> rvalid && rdata == {4'h0, $past(st_r.index)}) else $error("index read wrong");
endmodule : sicr_config_bank
`default_nettype wire

// ---- core/sicr_defs.svh ----
// Constants for the super I/O configuration register bank.
`ifndef SICR_DEFS_SVH
`define SICR_DEFS_SVH
`define SICR_INDEX_PORT 10'h3F0
`define SICR_DATA_PORT 10'h3F1
`define SICR_UNLOCK_VAL 8'h55
`define SICR_EXIT_VAL 8'hAA
`define SICR_IDX_FUNC 4'h0
`define SICR_IDX_PORT 4'h1
`define SICR_IDX_SERIAL 4'h2
`define SICR_IDX_FLOPPY 4'h3
`define SICR_FUNC_RST_PRI 8'h3B
`define SICR_FUNC_RST_SEC 8'h2B
`define SICR_PORT_RST 8'h9F
`define SICR_SERIAL_RST 8'hDC
`define SICR_FLOPPY_RST 8'h78
`define SICR_LPT_3BC 10'h3BC
`define SICR_LPT_378 10'h378
`define SICR_LPT_278 10'h278
`define SICR_COM_3F8 10'h3F8
`define SICR_COM_2F8 10'h2F8
`define SICR_FUNC_DISK_EN 0
`define SICR_FUNC_DISK_AT 1
`define SICR_FUNC_FDC_PWR 3
`define SICR_FUNC_FDC_EN 4
`define SICR_FUNC_OSC_LO 5
`define SICR_FUNC_VALID 7
`define SICR_PORT_LPT_PWR 2
`define SICR_PORT_LPT_STD 3
`define SICR_PORT_IRQ_POL 4
`define SICR_PORT_ALT_LO 5
`define SICR_PORT_LOCK 7
`define SICR_SER_U1_EN 2
`define SICR_SER_U1_PWR 3
`define SICR_SER_U2_LO 4
`define SICR_SER_U2_EN 6
`define SICR_SER_U2_PWR 7
`endif

// ---- core/sicr_pkg.sv ----
// Types for the super I/O configuration register bank.
package sicr_pkg;
    typedef enum logic [1:0] {SICR_CLOSED, SICR_ARMED, SICR_OPEN} sicr_mode_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [9:0] addr;
        logic [7:0] wdata;
    } sicr_bus_t;

    typedef struct packed {
        logic disk_en;
        logic disk_at;
        logic fdc_pwr;
        logic fdc_en;
        logic osc_run;
        logic brg_run;
        logic cfg_valid;
        logic lpt_en;
        logic [9:0] lpt_base;
        logic lpt_pwr;
        logic lpt_std;
        logic irq_pol_high;
        logic [1:0] alt_serial_sel;
        logic u1_en;
        logic u1_pwr;
        logic u1_alt;
        logic [1:0] u1_sel;
        logic [9:0] u1_base;
        logic u2_en;
        logic u2_pwr;
        logic u2_alt;
        logic [1:0] u2_sel;
        logic [9:0] u2_base;
    } sicr_ctl_t;

    typedef struct packed {
        sicr_mode_t mode;
        logic [3:0] index;
        logic [7:0] func;
        logic [7:0] port;
        logic [7:0] serial;
        logic [7:0] floppy;
        logic [7:0] rdata;
        logic rvalid;
    } sicr_state_t;
endpackage : sicr_pkg

// ---- tb/sicr_config_bank_tb_top.sv ----
// Self-checking testbench for the configuration register bank.
`include "sicr_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module sicr_config_bank_tb_top;
    import sicr_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic por = 1'b1;
    logic hard_rst = 1'b0;
    logic power_good_input = 1'b0;
    logic [2:0] irq_src = 3'h0;
    logic lpt_ext_mode = 1'b0;
    logic claim_seen = 1'b0;
    sicr_bus_t bus;
    logic [7:0] rdata;
    logic rvalid;
    logic claim;
    logic [2:0] irq_out;
    logic [2:0] irq_oe;
    sicr_ctl_t ctl;
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [7:0] d;
    logic v;
    logic [7:0] dflt [4] = '{`SICR_FUNC_RST_PRI, `SICR_PORT_RST, `SICR_SERIAL_RST,
        `SICR_FLOPPY_RST};
    always #50 clk = ~clk;
    sicr_config_bank dut (.clk(clk), .srst(srst), .por(por), .hard_rst(hard_rst),
        .bus(bus), .rdata(rdata), .rvalid(rvalid), .claim(claim),
        .power_good_input(power_good_input), .lpt_ext_mode(lpt_ext_mode), .irq_src(irq_src),
        .irq_out(irq_out), .irq_oe(irq_oe), .ctl(ctl));
    sicr_host host (.clk(clk), .bus(bus), .rdata(rdata), .rvalid(rvalid));
    always @(negedge clk) begin
        if (claim) begin
            claim_seen = 1'b1;
        end
    end
    task automatic ck(input logic [9:0] g, input logic [9:0] e);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %0t got %h expected %h", $time, g, e);
        end
    endtask : ck
    task automatic close_out;
        $display("mismatches %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : close_out
    task automatic t_defaults;
        host.unlock();
        for (int i = 0; i < 4; i++) begin
            host.rreg(i[3:0], d, v);
            ck({9'h0, v}, 10'h001);
            ck({2'h0, d}, {2'h0, dflt[i]});
        end
        ck(ctl.lpt_base, `SICR_LPT_278);
        ck(ctl.u1_base, `SICR_COM_3F8);
        ck(ctl.u2_base, `SICR_COM_2F8);
        ck({6'h0, ctl.u2_en, ctl.u1_en, ctl.u1_pwr, ctl.lpt_pwr}, 10'h00F);
        ck({7'h0, ctl.lpt_std, ctl.irq_pol_high, ctl.cfg_valid}, 10'h006);
        ck({9'h0, ctl.osc_run}, 10'h000);
        ck({9'h0, claim_seen}, 10'h001);
        $display("done defaults");
    endtask : t_defaults
    task automatic t_closed;
        host.leave();
        claim_seen = 1'b0;
        host.rd(`SICR_DATA_PORT, d, v);
        ck({9'h0, v}, 10'h000);
        host.acc(1'b0, `SICR_INDEX_PORT, `SICR_UNLOCK_VAL);
        host.acc(1'b1, 10'h2F8, 8'h00);
        host.acc(1'b0, `SICR_INDEX_PORT, `SICR_UNLOCK_VAL);
        host.rreg(4'h0, d, v);
        ck({9'h0, v}, 10'h000);
        ck({9'h0, claim_seen}, 10'h000);
        $display("done closed");
    endtask : t_closed
    task automatic t_write;
        host.unlock();
        @(posedge clk) power_good_input <= 1'b1;
        host.wreg(4'h0, 8'h6A);
        ck({7'h0, ctl.disk_en, ctl.disk_at, ctl.fdc_en}, 10'h002);
        ck({8'h0, ctl.osc_run, ctl.fdc_pwr}, 10'h001);
        host.wreg(4'h0, 8'hA3);
        ck({8'h0, ctl.osc_run, ctl.cfg_valid}, 10'h003);
        ck({9'h0, ctl.fdc_pwr}, 10'h000);
        @(posedge clk) srst <= 1'b1;
        @(posedge clk) srst <= 1'b0;
        host.unlock();
        host.rreg(4'h0, d, v);
        ck({1'b0, v, d}, 10'h1A3);
        host.wreg(4'h1, 8'h97);
        @(posedge clk) begin
            lpt_ext_mode <= 1'b1;
            irq_src <= 3'h4;
        end
        @(negedge clk);
        ck({6'h0, irq_oe[2], irq_out[2], irq_oe[0], irq_out[0]}, 10'h00A);
        @(posedge clk) irq_src <= 3'h0;
        @(negedge clk);
        ck({9'h0, irq_oe[2]}, 10'h000);
        @(posedge clk) lpt_ext_mode <= 1'b0;
        $display("done write");
    endtask : t_write
    task automatic t_lock;
        host.wreg(4'h1, 8'h0D);
        ck(ctl.lpt_base, `SICR_LPT_3BC);
        ck({7'h0, irq_oe}, 10'h000);
        @(posedge clk) irq_src <= 3'h1;
        @(negedge clk);
        ck({8'h0, irq_oe[0], irq_out[0]}, 10'h002);
        host.rreg(4'h1, d, v);
        ck({9'h0, v}, 10'h000);
        @(posedge clk) hard_rst <= 1'b1;
        @(posedge clk) hard_rst <= 1'b0;
        host.rreg(4'h1, d, v);
        ck({1'b0, v, d}, 10'h18D);
        $display("done lock");
    endtask : t_lock
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            close_out();
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        por <= 1'b0;
        srst <= 1'b0;
        t_defaults();
        t_closed();
        t_write();
        t_lock();
        close_out();
    end
endmodule : sicr_config_bank_tb_top
`default_nettype wire

// ---- tb/sicr_host.sv ----
// Host model that makes I/O cycles toward the configuration register bank.
`include "sicr_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module sicr_host (
    // Clock.
    input wire logic clk,
    // Host I/O bus.
    output var sicr_pkg::sicr_bus_t bus,
    input wire logic [7:0] rdata,
    input wire logic rvalid
);
    import sicr_pkg::*;
    initial bus = '{1'b0, 1'b0, 10'h000, 8'h00};
    // A released bus shows the inverse of its last address and data.
    task automatic acc(input logic r, input logic [9:0] a, input logic [7:0] x);
        @(posedge clk);
        bus <= '{r, ~r, a, x};
        @(posedge clk);
        bus <= '{1'b0, 1'b0, ~a, ~x};
    endtask : acc
    task automatic rd(input logic [9:0] a, output logic [7:0] x, output logic v);
        acc(1'b1, a, 8'h00);
        // The read answer stands for one cycle only, so take it before the next edge.
        @(negedge clk);
        x = rdata;
        v = rvalid;
    endtask : rd
    task automatic unlock;
        acc(1'b0, `SICR_INDEX_PORT, `SICR_UNLOCK_VAL);
        acc(1'b0, `SICR_INDEX_PORT, `SICR_UNLOCK_VAL);
    endtask : unlock
    task automatic leave;
        acc(1'b0, `SICR_INDEX_PORT, `SICR_EXIT_VAL);
    endtask : leave
    task automatic wreg(input logic [3:0] i, input logic [7:0] x);
        acc(1'b0, `SICR_INDEX_PORT, {4'h0, i});
        acc(1'b0, `SICR_DATA_PORT, x);
        @(negedge clk);
    endtask : wreg
    task automatic rreg(input logic [3:0] i, output logic [7:0] x, output logic v);
        acc(1'b0, `SICR_INDEX_PORT, {4'h0, i});
        rd(`SICR_DATA_PORT, x, v);
    endtask : rreg
endmodule : sicr_host
`default_nettype wire
